// >>> bench/embedded_memory_block_tb_top.sv
// Self-checking bench for the embedded memory block against a behavioural model.
`timescale 1ns/100ps
module embedded_memory_block_tb_top;
   import emb_mem_pkg::*;
   logic        clock = 1'b0, rst = 1'b1, slow = 1'b0, piped = 1'b0, regs_q = 1'b0;
   logic        chip_wide_clear_n = 1'b1, global_clear = 1'b0, local_clear_a = 1'b0;
   logic        local_clear_b = 1'b0, enable_a, enable_b, match;
   logic        reg_din = 1'b0, reg_dout = 1'b0, reg_raddr = 1'b0, reg_waddr = 1'b0;
   logic        reg_write_strobe = 1'b0, reg_fetch_gate = 1'b0;
   logic        write_strobe = 1'b0, fetch_gate = 1'b0;
   logic [15:0] din = 16'h0, dout;
   logic [4:0]  waddr = 5'h0, raddr = 5'h0, match_addr;
   logic [3:0]  clr_q = 4'h0;
   op_mode_t    op_mode = MODE_SPLIT_RW, mode_q = MODE_SPLIT_RW;
   int          mem[32], ed = 0, em = 0, ema = 0, n_fail = 0, num_checks = 0, cyc = 0;

   user_logic_model u_pace (.clock, .rst, .slow, .enable_a, .enable_b);
   embedded_memory_block u_dut (
      .clock, .rst, .chip_wide_clear_n, .global_clear, .local_clear_a, .local_clear_b,
      .enable_a, .enable_b, .op_mode, .reg_din, .reg_dout, .reg_raddr, .reg_waddr,
      .reg_write_strobe, .reg_fetch_gate, .din, .waddr, .raddr, .write_strobe,
      .fetch_gate, .dout, .match_addr, .match
   );

   // Free-running clock.
   always #4 clock = ~clock;

   // Cuts a hung run short.
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d fails=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One cycle of requests; checks the outcome of the previous cycle, then models this one.
   task automatic op(input logic we, input int wa, input int d, input logic rd, input int ra);
      logic ca, cb, rce;
      int   a;
      @(posedge clock);
      {write_strobe, fetch_gate, waddr, raddr, din} <= {we, rd, 5'(wa), 5'(ra), 16'(d)};
      {chip_wide_clear_n, global_clear, local_clear_a, local_clear_b} <= clr_q ^ 4'h8;
      {reg_din, reg_dout, reg_raddr, reg_waddr, reg_write_strobe, reg_fetch_gate} <= {6{regs_q}};
      op_mode <= mode_q;
      @(negedge clock);
      if (!piped) begin
         chk(dout, 16'(ed));
         chk(16'(match), 16'(em));
         chk(16'(match_addr), 16'(ema));
      end
      ca = !chip_wide_clear_n || global_clear || local_clear_a;
      cb = !chip_wide_clear_n || global_clear || local_clear_b;
      rce = (op_mode == MODE_SPLIT_RW) ? enable_b && !cb : enable_a && !ca;
      a = (op_mode == MODE_SINGLE) ? wa : ra;
      if (rd && rce && op_mode != MODE_CAM)
         ed = mem[a];
      if (enable_b && !cb) begin
         em = 0;
         ema = 0;
      end
      if (op_mode == MODE_CAM && enable_b && !cb) begin
         for (int i = 31; i >= 0; i--) begin
            if (mem[i] == d) begin
               em = 1;
               ema = i;
            end
         end
      end
      if (cb) begin
         ed = 0;
         em = 0;
         ema = 0;
      end
      if (we && enable_a && !ca)
         mem[wa] = d;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      int k;
      void'($urandom(87));
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      for (k = 0; k < 32; k++)
         op(1, k, $urandom % 65536, 0, 0);
      for (k = 0; k < 32; k++)
         op(1'(k), 31 - k, $urandom % 65536, 1, k);
      op(1, 5, 16'h1234, 1, 5);
      slow <= 1'b1;
      repeat (60) op(1'($urandom), $urandom % 32, $urandom % 65536, 1'($urandom), $urandom % 32);
      // Each clear source in turn, with a write and a read offered under it.
      for (k = 0; k < 4; k++) begin
         clr_q = 4'h1 << k;
         op(1, k, 16'h00ff, 1, k + 8);
         clr_q = 4'h0;
         op(0, 0, 0, 1, k);
      end
      slow <= 1'b0;
      mode_q = MODE_SINGLE;
      op(1, 9, 16'hbeef, 1, 3);
      op(0, 9, 0, 1, 3);
      mode_q = MODE_IN_OUT;
      // Side B enable drops at random here, so the output side must hold on its own.
      slow <= 1'b1;
      repeat (16) op(1'($urandom), $urandom % 32, $urandom % 65536, 1, $urandom % 32);
      slow <= 1'b0;
      mode_q = MODE_CAM;
      op(1, 14, 16'hfa12, 0, 0);
      op(1, 3, 16'hfa12, 0, 0);
      op(0, 0, 16'hfa12, 1, 2);
      slow <= 1'b1;
      for (k = 0; k < 30; k++)
         op(1'(k), $urandom % 32, k[0] ? $urandom % 65536 : mem[$urandom % 32], 1, 0);
      slow <= 1'b0;
      mode_q = MODE_SPLIT_RW;
      regs_q = 1'b1;
      op(0, 0, 0, 0, 0);
      piped = 1'b1;
      op(1, 7, 16'h5a5a, 0, 0);
      repeat (3) op(0, 0, 0, 0, 0);
      op(0, 0, 0, 1, 7);
      repeat (4) op(0, 0, 0, 0, 0);
      chk(dout, 16'h5a5a);
      tally_and_finish();
   end
endmodule

// >>> bench/user_logic_model.sv
// Model of the user logic that paces the memory block's two clock enables.
`timescale 1ns/100ps
module user_logic_model (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic slow,
   output logic      enable_a,
   output logic      enable_b
);
   logic [7:0] lfsr;
   // Enables move just after the edge; when slow, a shift pattern drops them at random.
   always_ff @(posedge clock) begin
      if (rst) begin
         lfsr     <= 8'h5a;
         enable_a <= 1'b1;
         enable_b <= 1'b1;
      end else begin
         lfsr     <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         enable_a <= !slow || lfsr[1];
         enable_b <= !slow || lfsr[6];
      end
   end
endmodule

// >>> rtl/emb_mem_pkg.sv
// Shared constants and mode encodings for the embedded memory block.
package emb_mem_pkg;

   // ----------------------------------------------------------------
   // Default geometry and address-width limit
   // ----------------------------------------------------------------
   localparam int DATA_W_DEF = 16;
   localparam int ADDR_W_DEF = 5;
   localparam int ADDR_W_MAX = 12;

   // ----------------------------------------------------------------
   // Operating modes, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      MODE_SPLIT_RW = 4'h1,
      MODE_IN_OUT   = 4'h2,
      MODE_SINGLE   = 4'h4,
      MODE_CAM      = 4'h8
   } op_mode_t;

endpackage

// >>> rtl/embedded_memory_block.sv
// Embedded memory block: dual-port, single-port or content-addressable storage.
`timescale 1ns/100ps
module embedded_memory_block #(
   parameter int DATA_W = emb_mem_pkg::DATA_W_DEF,
   parameter int ADDR_W = emb_mem_pkg::ADDR_W_DEF
) (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic                 chip_wide_clear_n,
   input  wire logic                 global_clear,
   input  wire logic                 local_clear_a,
   input  wire logic                 local_clear_b,
   input  wire logic                 enable_a,
   input  wire logic                 enable_b,
   input  emb_mem_pkg::op_mode_t     op_mode,
   input  wire logic                 reg_din,
   input  wire logic                 reg_dout,
   input  wire logic                 reg_raddr,
   input  wire logic                 reg_waddr,
   input  wire logic                 reg_write_strobe,
   input  wire logic                 reg_fetch_gate,
   input  wire logic [DATA_W-1:0]    din,
   input  wire logic [ADDR_W-1:0]    waddr,
   input  wire logic [ADDR_W-1:0]    raddr,
   input  wire logic                 write_strobe,
   input  wire logic                 fetch_gate,
   output logic      [DATA_W-1:0]    dout,
   output logic      [ADDR_W-1:0]    match_addr,
   output logic                      match
);
   import emb_mem_pkg::*;

   localparam int DEPTH = 1 << ADDR_W;

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (DATA_W < 1 || ADDR_W < 1 || ADDR_W > ADDR_W_MAX) begin : g_bad_geometry
      $error("embedded_memory_block: unsupported geometry");
   end

   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] mem [DEPTH];
   logic [DATA_W-1:0] din_q,     next_din_q;
   logic [ADDR_W-1:0] waddr_q,   next_waddr_q;
   logic [ADDR_W-1:0] raddr_q,   next_raddr_q;
   logic              we_q,      next_we_q;
   logic              fetch_q,   next_fetch_q;
   logic [DATA_W-1:0] rd_stage,  next_rd_stage;
   logic [DATA_W-1:0] next_dout;
   logic [ADDR_W-1:0] next_match_addr;
   logic              next_match;

   logic              clear_a, clear_b, rd_in_clr, rd_in_ce;
   logic              is_split, is_cam;
   logic [DATA_W-1:0] din_e, mem_q;
   logic [ADDR_W-1:0] waddr_e, raddr_e, rd_addr_e;
   logic              we_e, fetch_e, wr_fire, rd_fire;
   logic              hit;
   logic [ADDR_W-1:0] hit_addr;

   // Side clears; the chip-wide clear and reset beat every enable.
   assign clear_a  = rst | ~chip_wide_clear_n | global_clear | local_clear_a;
   assign clear_b  = rst | ~chip_wide_clear_n | global_clear | local_clear_b;
   assign is_split = (op_mode == MODE_SPLIT_RW);
   assign is_cam   = (op_mode == MODE_CAM);

   // Read-side input registers follow side B only when reads and writes are split.
   assign rd_in_ce  = is_split ? enable_b : enable_a;
   assign rd_in_clr = is_split ? clear_b  : clear_a;

   // Each path picks its registered copy or the live port.
   assign din_e     = reg_din          ? din_q   : din;
   assign waddr_e   = reg_waddr        ? waddr_q : waddr;
   assign raddr_e   = reg_raddr        ? raddr_q : raddr;
   assign we_e      = reg_write_strobe ? we_q    : write_strobe;
   assign fetch_e   = reg_fetch_gate   ? fetch_q : fetch_gate;
   assign rd_addr_e = (op_mode == MODE_SINGLE) ? waddr_e : raddr_e;
   assign wr_fire   = we_e & enable_a & ~clear_a;
   assign rd_fire   = fetch_e & rd_in_ce & ~rd_in_clr & ~is_cam;
   assign mem_q     = mem[rd_addr_e];

   // ----------------------------------------------------------------
   // Parallel search, lowest matching address wins
   // ----------------------------------------------------------------
   always_comb begin
      hit      = 1'b0;
      hit_addr = '0;
      for (int i = DEPTH - 1; i >= 0; i--) begin
         if (mem[i] == din_e) begin
            hit      = 1'b1;
            hit_addr = ADDR_W'(i);
         end
      end
   end

   // ----------------------------------------------------------------
   // Next values of the input registers
   // ----------------------------------------------------------------
   always_comb begin
      next_din_q   = din_q;
      next_waddr_q = waddr_q;
      next_we_q    = we_q;
      next_raddr_q = raddr_q;
      next_fetch_q = fetch_q;
      if (clear_a) begin
         next_din_q   = '0;
         next_waddr_q = '0;
         next_we_q    = 1'b0;
      end else if (enable_a) begin
         next_din_q   = din;
         next_waddr_q = waddr;
         next_we_q    = write_strobe;
      end
      if (rd_in_clr) begin
         next_raddr_q = '0;
         next_fetch_q = 1'b0;
      end else if (rd_in_ce) begin
         next_raddr_q = raddr;
         next_fetch_q = fetch_gate;
      end
   end

   // Input registers.
   always_ff @(posedge clock) begin
      din_q   <= next_din_q;
      waddr_q <= next_waddr_q;
      we_q    <= next_we_q;
      raddr_q <= next_raddr_q;
      fetch_q <= next_fetch_q;
   end

   // Array write; a same-cycle read sees the old word.
   always_ff @(posedge clock) begin
      if (wr_fire) begin
         mem[waddr_e] <= din_e;
      end
   end

   // ----------------------------------------------------------------
   // Next values of the output side
   // ----------------------------------------------------------------
   always_comb begin
      next_rd_stage   = rd_fire ? mem_q : rd_stage;
      next_dout       = dout;
      next_match      = match;
      next_match_addr = match_addr;
      if (reg_dout) begin
         if (enable_b) begin
            next_dout = rd_stage;
         end
      end else if (rd_fire) begin
         next_dout = mem_q;
      end
      if (enable_b) begin
         next_match      = is_cam & hit;
         next_match_addr = is_cam ? hit_addr : '0;
      end
      if (clear_b) begin
         next_rd_stage   = '0;
         next_dout       = '0;
         next_match      = 1'b0;
         next_match_addr = '0;
      end
   end

   // Output registers.
   always_ff @(posedge clock) begin
      rd_stage   <= next_rd_stage;
      dout       <= next_dout;
      match      <= next_match;
      match_addr <= next_match_addr;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   write_lands_a : assert property (
      wr_fire |=> mem[$past(waddr_e)] == $past(din_e))
      else $error("written word not stored");

   old_data_read_a : assert property (
      rd_fire && !reg_dout && !clear_b |=> dout == $past(mem_q))
      else $error("unregistered read did not return array word");

   out_pipeline_a : assert property (
      rd_fire && reg_dout && !clear_b ##1 reg_dout && enable_b && !clear_b
      |=> dout == $past(mem_q, 2))
      else $error("registered read word wrong after two edges");

   write_side_hold_a : assert property (
      is_split && !enable_a && !clear_a |=> $stable(waddr_q) && $stable(we_q) && $stable(din_q))
      else $error("write side moved without its enable");

   read_side_hold_a : assert property (
      is_split && !enable_b && !clear_b |=> $stable(raddr_q) && $stable(fetch_q))
      else $error("read side moved without its enable");

   side_isolation_a : assert property (
      is_split && clear_b && !clear_a && enable_a |=> waddr_q == $past(waddr))
      else $error("side B clear disturbed side A");

   io_input_clock_a : assert property (
      op_mode == MODE_IN_OUT && enable_a && !clear_a |=> raddr_q == $past(raddr))
      else $error("input side did not load read address");

   // With the output register bypassed, read data follows the input side instead.
   io_output_hold_a : assert property (
      op_mode == MODE_IN_OUT && !enable_b && !clear_b
      |=> $stable(match) && $stable(match_addr) && (!$past(reg_dout) || $stable(dout)))
      else $error("output register moved without side B enable");

   single_port_a : assert property (
      op_mode == MODE_SINGLE && rd_fire && !reg_dout && !clear_b
      |=> dout == $past(mem[waddr_e]))
      else $error("single port read used wrong address");

   cam_result_a : assert property (
      is_cam && enable_b && !clear_b
      |=> match == $past(hit) && match_addr == $past(hit_addr))
      else $error("search result not registered");

   // Every location compared with the search word, so that no lower match can hide.
   logic [DEPTH-1:0] eq_vec;
   always_comb begin
      for (int j = 0; j < DEPTH; j++) begin
         eq_vec[j] = (mem[j] == din_e);
      end
   end

   cam_lowest_a : assert property (
      hit |-> mem[hit_addr] == din_e
          && (eq_vec & ((DEPTH'(1) << hit_addr) - DEPTH'(1))) == '0)
      else $error("search did not report lowest matching address");

   chip_clear_a : assert property (
      !chip_wide_clear_n |=> dout == '0 && !match && waddr_q == '0 && !we_q && !fetch_q)
      else $error("chip-wide clear did not clear registers");

   side_a_clear_a : assert property (
      local_clear_a |=> !we_q && din_q == '0)
      else $error("local clear left side A set");

   rw_same_cycle_c : cover property (is_split && wr_fire && rd_fire);
   cam_hit_c       : cover property (is_cam && enable_b ##1 match);
   pipe_read_c     : cover property (rd_fire && reg_dout ##1 enable_b);
   single_rw_c     : cover property (op_mode == MODE_SINGLE && wr_fire && rd_fire);

endmodule
